// ---- logic/fcd_host.sv ----
// host controller issuing command sequences to the four-bank flash pins
//
// Behaviour
// - program is two unlock writes, A0H, then data
// - sector erase: six writes, sector addr, 50H
// - block erase: six writes, block addr, 30H
// - chip erase: six writes, 555H/10H last
// - suspend B0H, resume 30H, single write
// - secid program: four writes, A5H then data
// - host finishes all four secid writes
// - lock: 555H/85H then 0000H, word mode
// - id entry: two unlocks then bank 90H
// - query entry long or 55H/98H short
// - exit long or single F0H, equivalent
`timescale 1ns/10ps
module fcd_host
  import fcd_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        req_valid,
  output logic             req_ready,
  input  wire fcd_req_t    req,
  input  wire logic        byte_mode,
  output logic             rsp_valid,
  output logic [15:0]      rsp_data,
  output logic             busy,
  output logic             dev_ready,
  output logic [19:0]      fl_addr,
  output logic             fl_addr_m1,
  input  wire logic [15:0] fl_dq_i,
  output logic [15:0]      fl_dq_o,
  output logic             fl_dq_oe,
  output logic             fl_ce_n,
  output logic             fl_oe_n,
  output logic             fl_we_n,
  output logic             fl_rst_n,
  output logic             fl_byte_n,
  input  wire logic        ready_busy_n
);

  typedef enum logic [2:0] {
    FCD_IDLE, FCD_WR_LOW, FCD_WR_HIGH, FCD_RD, FCD_RST_LOW, FCD_RST_HIGH
  } fcd_state_t;

  fcd_state_t       state_q;
  fcd_wr_t          seq_q [6];
  logic [2:0]       seq_len_q;
  logic [2:0]       seq_idx_q;
  logic [CNT_W-1:0] cnt_q;
  logic [15:0]      dq_s1_q, dq_s2_q;
  logic             rb_s1_q, rb_s2_q;
  logic             byte_q;

  // build one write from low address and low data byte
  function automatic fcd_wr_t cmd(input logic [19:0] hi, input logic [10:0] a, input logic [7:0] d);
    return '{addr: {hi[19:11], a}, data: {8'h00, d}};
  endfunction

  // sequence length per opcode
  function automatic logic [2:0] op_len(input fcd_op_t op);
    case (op)
      FCD_OP_PROG, FCD_OP_SECID_PROG, FCD_OP_SECID_LOCK: op_len = 3'd4;
      FCD_OP_SECT_ERASE, FCD_OP_BLK_ERASE, FCD_OP_CHIP_ERASE: op_len = 3'd6;
      FCD_OP_SECID_QUERY, FCD_OP_ID_ENTRY, FCD_OP_QRY_ENTRY, FCD_OP_EXIT_LONG: op_len = 3'd3;
      default: op_len = 3'd1;
    endcase
  endfunction

  // pin synchronisers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dq_s1_q <= 16'h0000;
      dq_s2_q <= 16'h0000;
      rb_s1_q <= 1'b0;
      rb_s2_q <= 1'b0;
    end else begin
      dq_s1_q <= fl_dq_i;
      dq_s2_q <= dq_s1_q;
      rb_s1_q <= ready_busy_n;
      rb_s2_q <= rb_s1_q;
    end
  end

  assign dev_ready = rb_s2_q;
  assign req_ready = (state_q == FCD_IDLE);
  assign busy      = (state_q != FCD_IDLE);
  assign fl_byte_n = ~byte_q;

  // main sequencer
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q   <= FCD_IDLE;
      seq_len_q <= 3'd0;
      seq_idx_q <= 3'd0;
      cnt_q     <= '0;
      byte_q    <= 1'b0;
      fl_addr   <= 20'h00000;
      fl_addr_m1 <= 1'b0;
      fl_dq_o   <= 16'h0000;
      fl_dq_oe  <= 1'b0;
      fl_ce_n   <= 1'b1;
      fl_oe_n   <= 1'b1;
      fl_we_n   <= 1'b1;
      fl_rst_n  <= 1'b1;
      rsp_valid <= 1'b0;
      rsp_data  <= 16'h0000;
      for (int i = 0; i < 6; i++) begin
        seq_q[i] <= '0;
      end
    end else begin
      rsp_valid <= 1'b0;
      case (state_q)
        FCD_IDLE: begin
          if (req_valid) begin
            // lock must be issued in word mode
            byte_q <= (req.op == FCD_OP_SECID_LOCK) ? 1'b0 : byte_mode;
            seq_idx_q <= 3'd0;
            seq_len_q <= op_len(req.op);
            cnt_q <= '0;
            // unlock prefix common to most sequences
            seq_q[0] <= cmd(req.addr, A_555, D_AA);
            seq_q[1] <= cmd(req.addr, A_2AA, D_55);
            seq_q[3] <= cmd(req.addr, A_555, D_AA);
            seq_q[4] <= cmd(req.addr, A_2AA, D_55);
            case (req.op)
              FCD_OP_READ: begin
                state_q <= FCD_RD;
              end
              FCD_OP_HW_RESET: begin
                state_q <= FCD_RST_LOW;
              end
              FCD_OP_PROG: begin
                seq_q[2] <= cmd(req.addr, A_555, D_PROG);
                seq_q[3] <= '{addr: req.addr, data: req.data};
                state_q  <= FCD_WR_LOW;
              end
              FCD_OP_SECID_PROG: begin
                // all four writes issued back to back
                seq_q[2] <= cmd(req.addr, A_555, D_SPRG);
                seq_q[3] <= '{addr: req.addr, data: req.data};
                state_q  <= FCD_WR_LOW;
              end
              FCD_OP_SECID_LOCK: begin
                seq_q[2] <= cmd(req.addr, A_555, D_SLCK);
                seq_q[3] <= '{addr: req.addr, data: D_LOCK_WORD};
                state_q  <= FCD_WR_LOW;
              end
              FCD_OP_SECT_ERASE, FCD_OP_BLK_ERASE, FCD_OP_CHIP_ERASE: begin
                seq_q[2] <= cmd(req.addr, A_555, D_ERS);
                if (req.op == FCD_OP_SECT_ERASE) begin
                  seq_q[5] <= '{addr: req.addr, data: {8'h00, D_SEC}};
                end else if (req.op == FCD_OP_BLK_ERASE) begin
                  seq_q[5] <= '{addr: req.addr, data: {8'h00, D_BLK}};
                end else begin
                  seq_q[5] <= cmd(req.addr, A_555, D_CHIP);
                end
                state_q <= FCD_WR_LOW;
              end
              FCD_OP_SUSPEND: begin
                seq_q[0] <= cmd(req.addr, A_ANY, D_SUSP);
                state_q  <= FCD_WR_LOW;
              end
              FCD_OP_RESUME: begin
                seq_q[0] <= cmd(req.addr, A_ANY, D_RES);
                state_q  <= FCD_WR_LOW;
              end
              FCD_OP_SECID_QUERY: begin
                seq_q[2] <= cmd(req.addr, A_555, D_SQRY);
                state_q  <= FCD_WR_LOW;
              end
              FCD_OP_ID_ENTRY: begin
                seq_q[2] <= cmd(req.addr, A_555, D_ID);
                state_q  <= FCD_WR_LOW;
              end
              FCD_OP_QRY_ENTRY: begin
                seq_q[2] <= cmd(req.addr, A_555, D_QRY);
                state_q  <= FCD_WR_LOW;
              end
              FCD_OP_QRY_SHORT: begin
                seq_q[0] <= cmd(req.addr, A_55, D_QRY);
                state_q  <= FCD_WR_LOW;
              end
              FCD_OP_EXIT_LONG: begin
                seq_q[2] <= cmd(req.addr, A_555, D_EXIT);
                state_q  <= FCD_WR_LOW;
              end
              FCD_OP_EXIT_SHORT: begin
                seq_q[0] <= cmd(req.addr, A_ANY, D_EXIT);
                state_q  <= FCD_WR_LOW;
              end
              default: begin
                state_q <= FCD_IDLE;
              end
            endcase
          end
        end
        FCD_WR_LOW: begin
          // write strobe low, address and data held
          fl_addr    <= seq_q[seq_idx_q].addr;
          fl_addr_m1 <= 1'b0;
          fl_dq_o    <= seq_q[seq_idx_q].data;
          fl_dq_oe   <= 1'b1;
          fl_ce_n    <= 1'b0;
          fl_oe_n    <= 1'b1;
          fl_we_n    <= 1'b0;
          cnt_q      <= cnt_q + 1'b1;
          if (cnt_q == CNT_W'(WP_CYC)) begin
            fl_we_n <= 1'b1;
            cnt_q   <= '0;
            state_q <= FCD_WR_HIGH;
          end
        end
        FCD_WR_HIGH: begin
          // strobe high; data held one more write-high period
          fl_ce_n <= 1'b1;
          cnt_q   <= cnt_q + 1'b1;
          if (cnt_q == CNT_W'(WPH_CYC)) begin
            fl_dq_oe <= 1'b0;
            cnt_q    <= '0;
            if (seq_idx_q == seq_len_q - 3'd1) begin
              state_q <= FCD_IDLE;
            end else begin
              seq_idx_q <= seq_idx_q + 3'd1;
              state_q   <= FCD_WR_LOW;
            end
          end
        end
        FCD_RD: begin
          // array, id, query or lock read; wait access plus sync
          fl_addr    <= seq_q[0].addr;
          fl_addr_m1 <= 1'b0;
          fl_dq_oe   <= 1'b0;
          fl_ce_n    <= 1'b0;
          fl_oe_n    <= 1'b0;
          fl_we_n    <= 1'b1;
          cnt_q      <= cnt_q + 1'b1;
          if (cnt_q == CNT_W'(IDA_CYC + 2)) begin
            rsp_data  <= byte_q ? {8'h00, dq_s2_q[7:0]} : dq_s2_q;
            rsp_valid <= 1'b1;
            fl_ce_n   <= 1'b1;
            fl_oe_n   <= 1'b1;
            cnt_q     <= '0;
            state_q   <= FCD_IDLE;
          end
        end
        FCD_RST_LOW: begin
          fl_rst_n <= 1'b0;
          fl_ce_n  <= 1'b1;
          fl_we_n  <= 1'b1;
          fl_oe_n  <= 1'b1;
          fl_dq_oe <= 1'b0;
          cnt_q    <= cnt_q + 1'b1;
          if (cnt_q == CNT_W'(RP_CYC)) begin
            fl_rst_n <= 1'b1;
            cnt_q    <= '0;
            state_q  <= FCD_RST_HIGH;
          end
        end
        FCD_RST_HIGH: begin
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q == CNT_W'(RHR_CYC)) begin
            cnt_q   <= '0;
            state_q <= FCD_IDLE;
          end
        end
        default: begin
          state_q <= FCD_IDLE;
        end
      endcase
      // read requests keep the address in slot 0
      if (state_q == FCD_IDLE && req_valid && req.op == FCD_OP_READ) begin
        seq_q[0] <= '{addr: req.addr, data: 16'h0000};
      end
    end
  end

  // strobe low lasts the write pulse
  sequence s_we_low;
    !fl_we_n [*4];
  endsequence
  a_we_pulse_len: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $fell(fl_we_n) |-> s_we_low)
    else $error("write pulse too short");
  // data enabled whenever write strobe low
  a_dq_drive_we: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !fl_we_n |-> fl_dq_oe && !fl_ce_n && fl_oe_n)
    else $error("write without data drive");
  // lock is always issued in word mode
  a_lock_word: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state_q == FCD_IDLE && req_valid && req.op == FCD_OP_SECID_LOCK) |=> !byte_q)
    else $error("lock issued in byte mode");
  // hardware reset pulse held at least eight cycles
  sequence s_rst_low;
    !fl_rst_n [*8];
  endsequence
  a_rst_pulse: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $fell(fl_rst_n) |-> s_rst_low)
    else $error("reset pulse short");
  // no new request taken mid-sequence
  a_seq_atomic: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state_q == FCD_WR_HIGH && seq_idx_q < seq_len_q - 3'd1 && cnt_q == CNT_W'(WPH_CYC))
    |=> state_q == FCD_WR_LOW)
    else $error("sequence broken early");
  // byte mode answer has zero upper byte
  a_byte_low: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (rsp_valid && byte_q) |-> rsp_data[15:8] == 8'h00)
    else $error("upper byte in byte mode");
  // short exit ends after one write
  a_short_len: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state_q == FCD_IDLE && req_valid && req.op == FCD_OP_EXIT_SHORT) |=> seq_len_q == 3'd1)
    else $error("short exit not single write");
  // chip erase sequence runs six writes
  a_erase_len: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state_q == FCD_IDLE && req_valid && req.op == FCD_OP_CHIP_ERASE) |=> seq_len_q == 3'd6)
    else $error("erase not six writes");
endmodule

// ---- logic/fcd_pkg.sv ----
// package: command codes, addresses, pin timing for the flash command host
package fcd_pkg;
  localparam int unsigned CLK_PERIOD_NS = 10;
  // bus cycle timing, ns
  localparam int unsigned T_WP_NS   = 40;
  localparam int unsigned T_WPH_NS  = 30;
  localparam int unsigned T_RC_NS   = 70;
  localparam int unsigned T_RP_NS   = 500;
  localparam int unsigned T_RHR_NS  = 50;
  localparam int unsigned T_IDA_NS  = 150;
  localparam int unsigned WP_CYC   = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WPH_CYC  = (T_WPH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RC_CYC   = (T_RC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RP_CYC   = (T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RHR_CYC  = (T_RHR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned IDA_CYC  = (T_IDA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W    = 8;

  // command addresses and data
  localparam logic [10:0] A_555 = 11'h555;
  localparam logic [10:0] A_2AA = 11'h2AA;
  localparam logic [10:0] A_55  = 11'h055;
  localparam logic [10:0] A_ANY = 11'h000;
  localparam logic [7:0] D_AA   = 8'hAA;
  localparam logic [7:0] D_55   = 8'h55;
  localparam logic [7:0] D_PROG = 8'hA0;
  localparam logic [7:0] D_ERS  = 8'h80;
  localparam logic [7:0] D_SEC  = 8'h50;
  localparam logic [7:0] D_BLK  = 8'h30;
  localparam logic [7:0] D_CHIP = 8'h10;
  localparam logic [7:0] D_SUSP = 8'hB0;
  localparam logic [7:0] D_RES  = 8'h30;
  localparam logic [7:0] D_SQRY = 8'h88;
  localparam logic [7:0] D_SPRG = 8'hA5;
  localparam logic [7:0] D_SLCK = 8'h85;
  localparam logic [7:0] D_ID   = 8'h90;
  localparam logic [7:0] D_QRY  = 8'h98;
  localparam logic [7:0] D_EXIT = 8'hF0;
  localparam logic [15:0] D_LOCK_WORD = 16'h0000;
  localparam logic [19:0] SECID_LO = 20'h00008;
  localparam logic [19:0] SECID_HI = 20'h00087;
  localparam logic [19:0] SEC_LOCK_ADDR = 20'h000FF;
  localparam int unsigned LOCK_BIT = 3;
  localparam int unsigned SECID_BIT = 3;
  localparam int unsigned SEC_LSB = 11;
  localparam int unsigned BLK_LSB = 15;
  localparam int unsigned BANK_LSB = 18;
  localparam logic [19:0] ID_MAKER_OFS = 20'h00000;
  localparam logic [19:0] ID_PART_OFS  = 20'h00001;
  localparam logic [19:0] QRY_STR_OFS  = 20'h00010;
  localparam logic [19:0] QRY_LAST_OFS = 20'h00034;

  // host opcodes
  typedef enum logic [3:0] {
    FCD_OP_READ, FCD_OP_PROG, FCD_OP_SECT_ERASE, FCD_OP_BLK_ERASE, FCD_OP_CHIP_ERASE,
    FCD_OP_SUSPEND, FCD_OP_RESUME, FCD_OP_SECID_QUERY, FCD_OP_SECID_PROG, FCD_OP_SECID_LOCK,
    FCD_OP_ID_ENTRY, FCD_OP_QRY_ENTRY, FCD_OP_QRY_SHORT, FCD_OP_EXIT_LONG, FCD_OP_EXIT_SHORT,
    FCD_OP_HW_RESET
  } fcd_op_t;

  // one bus write on the pins
  typedef struct packed {
    logic [19:0] addr;
    logic [15:0] data;
  } fcd_wr_t;

  // host request
  typedef struct packed {
    fcd_op_t     op;
    logic [19:0] addr;
    logic [15:0] data;
  } fcd_req_t;
endpackage

// ---- verification/fcd_flash_model.sv ----
// behavioural flash device as seen from its pins
`timescale 1ns/10ps
module fcd_flash_model
  import fcd_pkg::*;
#(
  parameter logic [15:0] MAKER_ID = 16'h00C3, // arbitrary value
  parameter logic [15:0] PART_ID  = 16'h5A21, // arbitrary value
  parameter logic [15:0] FACT_ID  = 16'h6D6D  // arbitrary value
)(
  input  wire logic [19:0] fl_addr,
  input  wire logic [15:0] fl_dq_o,
  input  wire logic        fl_ce_n,
  input  wire logic        fl_oe_n,
  input  wire logic        fl_we_n,
  input  wire logic        fl_rst_n,
  input  wire logic        fl_byte_n,
  output logic [15:0]      fl_dq_i,
  output logic             ready_busy_n
);
  // query table, word offsets 10H to 34H
  localparam logic [7:0] QT [0:36] = '{8'h51, 8'h52, 8'h59, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h27, 8'h36, 8'h00, 8'h00, 8'h04, 8'h00, 8'h04, 8'h06, 8'h01, 8'h00, 8'h01, 8'h01, 8'h15,
    8'h02, 8'h00, 8'h00, 8'h00, 8'h02, 8'hFF, 8'h01, 8'h10, 8'h00, 8'h1F, 8'h00, 8'h00, 8'h01};
  logic [10:0] ha [0:5];
  logic [7:0]  hd [0:5];
  logic [15:0] usr [0:255];
  logic [15:0] rd;
  logic [1:0]  bank   = 2'h0;
  logic [1:0]  mode   = 2'h0;
  logic        locked = 1'b0;
  logic        rb     = 1'b1;
  logic        tg     = 1'b0;
  function automatic logic [15:0] query_word(input logic [7:0] o);
    return (o >= 8'h10 && o <= 8'h34) ? {8'h00, QT[o - 8'h10]} : 16'h0000;
  endfunction
  function automatic logic unl(input int k);
    return ha[k] == A_555 && hd[k] == D_AA && ha[k - 1] == A_2AA && hd[k - 1] == D_55;
  endfunction
  task automatic done();
    for (int i = 0; i < 6; i++) hd[i] = 8'h00;
  endtask
  // an internal operation holds ready low for a while
  task automatic work();
    done();
    rb = 1'b0;
    rb <= #300 1'b1;
  endtask
  // changing pattern for undriven lines
  always #5 tg = ~tg;
  initial for (int i = 0; i < 256; i++) usr[i] = 16'hFFFF;
  // decode on the write strobe's rising edge; a stray write breaks the pattern
  always @(posedge fl_we_n) begin
    if (!fl_ce_n && fl_rst_n) begin
      for (int i = 5; i > 0; i--) begin
        ha[i] = ha[i - 1];
        hd[i] = hd[i - 1];
      end
      ha[0] = fl_addr[10:0];
      hd[0] = fl_dq_o[7:0];
      if (unl(5) && ha[3] == A_555 && hd[3] == D_ERS && unl(2) && (hd[0] == D_SEC || hd[0] == D_BLK ||
          (hd[0] == D_CHIP && ha[0] == A_555))) begin
        work();
      end else if (unl(3) && ha[1] == A_555 && hd[1] == D_PROG) begin
        work();
      end else if (unl(3) && ha[1] == A_555 && hd[1] == D_SPRG) begin
        if (!locked && fl_addr >= SECID_LO && fl_addr <= SECID_HI) usr[fl_addr[7:0]] &= fl_dq_o;
        done();
      end else if (unl(3) && ha[1] == A_555 && hd[1] == D_SLCK) begin
        locked = locked | (fl_dq_o == D_LOCK_WORD && fl_byte_n);
        done();
      end else if (unl(2) && ha[0] == A_555 && hd[0] inside {D_ID, D_QRY, D_SQRY, D_EXIT}) begin
        if (hd[0] != D_EXIT || rb) mode = (hd[0] == D_ID) ? 2'h1 : (hd[0] == D_QRY) ? 2'h2 : (hd[0] == D_SQRY) ? 2'h3 : 2'h0;
        bank = fl_addr[19:18];
        done();
      end else if (ha[0] == A_55 && hd[0] == D_QRY) begin
        mode = 2'h2;
        done();
      end else if (hd[0] == D_EXIT || hd[0] == D_SUSP || hd[0] == D_RES) begin
        if (hd[0] == D_EXIT && rb) mode = 2'h0;
        done();
      end
    end
  end
  // hardware reset abandons sequence and mode
  always @(negedge fl_rst_n) begin
    mode = 2'h0;
    done();
  end
  // read data by mode
  always_comb begin
    rd = ~fl_addr[15:0];
    if (mode == 2'h1 && fl_addr[19:18] == bank)
      rd = (fl_addr[17:1] == 17'h0) ? (fl_addr[0] ? PART_ID : MAKER_ID) : 16'h0000;
    if (mode == 2'h2) rd = query_word(fl_addr[7:0]);
    if (mode == 2'h3)
      rd = (fl_addr[7:0] == 8'hFF) ? {12'h000, ~locked, 3'h0} : (fl_addr >= SECID_LO && fl_addr <= SECID_HI) ?
           usr[fl_addr[7:0]] : FACT_ID;
    if (!fl_byte_n) rd[15:8] = {8{tg}};
  end
  assign fl_dq_i      = (!fl_ce_n && !fl_oe_n && fl_rst_n) ? rd : {16{tg}} ^ 16'h5A5A;
  assign ready_busy_n = rb;
endmodule

// ---- verification/fcd_host_bench.sv ----
// self-checking bench: host controller against the flash model
`timescale 1ns/10ps
module fcd_host_bench
  import fcd_pkg::*;
;
  localparam logic [15:0] MAKER = 16'h00C3; // arbitrary value
  localparam logic [15:0] PART  = 16'h5A21; // arbitrary value
  localparam logic [15:0] FACT  = 16'h6D6D; // arbitrary value
  // query table words 10H to 34H, low bytes
  localparam logic [7:0] QX [0:36] = '{8'h51, 8'h52, 8'h59, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h27, 8'h36, 8'h00, 8'h00, 8'h04, 8'h00, 8'h04, 8'h06, 8'h01, 8'h00, 8'h01, 8'h01, 8'h15,
    8'h02, 8'h00, 8'h00, 8'h00, 8'h02, 8'hFF, 8'h01, 8'h10, 8'h00, 8'h1F, 8'h00, 8'h00, 8'h01};
  typedef struct packed {fcd_wr_t w; logic [1:0] k;} fcd_exp_t;
  logic        clk_sys = 1'b0, rst_n = 1'b0, req_valid = 1'b0, byte_mode = 1'b0;
  fcd_req_t    req = '0;
  logic        req_ready, rsp_valid, busy, dev_ready, fl_ce_n, fl_oe_n, fl_we_n, fl_rst_n, fl_byte_n, ready_busy_n;
  logic        fl_dq_oe, fl_addr_m1;
  logic [15:0] rsp_data, fl_dq_i, fl_dq_o, d1, d2;
  logic [19:0] fl_addr, a;
  logic [7:0]  lf = 8'd76;
  fcd_exp_t    wq [$];
  logic [15:0] rq [$];
  int          fails = 0, n_compared = 0;
  fcd_host u_dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .req_valid(req_valid), .req_ready(req_ready), .req(req),
    .byte_mode(byte_mode), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .busy(busy), .dev_ready(dev_ready),
    .fl_addr(fl_addr), .fl_addr_m1(fl_addr_m1), .fl_dq_i(fl_dq_i), .fl_dq_o(fl_dq_o), .fl_dq_oe(fl_dq_oe),
    .fl_ce_n(fl_ce_n),
    .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n), .fl_rst_n(fl_rst_n), .fl_byte_n(fl_byte_n), .ready_busy_n(ready_busy_n));
  fcd_flash_model #(.MAKER_ID(MAKER), .PART_ID(PART), .FACT_ID(FACT)) u_mem (
    .fl_addr(fl_addr), .fl_dq_o(fl_dq_o), .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n),
    .fl_rst_n(fl_rst_n), .fl_byte_n(fl_byte_n), .fl_dq_i(fl_dq_i), .ready_busy_n(ready_busy_n));
  // clock
  initial forever #5 clk_sys = ~clk_sys;
  function automatic logic [15:0] rnd();
    logic [7:0] h;
    h  = {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
    lf = {h[6:0], h[7] ^ h[5] ^ h[4] ^ h[3]};
    return {h, lf};
  endfunction
  task automatic end_sim();
    if (wq.size() != 0 || rq.size() != 0) begin
      fails++;
      $display("BAD %0t results missing", $time);
    end
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // kinds: 0 low addr and byte, 1 whole write, 2 data word, 3 full addr and byte
  task automatic cmp_wr(input fcd_wr_t g);
    fcd_exp_t e;
    logic     ok;
    e = (wq.size() != 0) ? wq.pop_front() : '1;
    n_compared++;
    case (e.k)
      2'd0: ok = g.addr[10:0] === e.w.addr[10:0] && g.data[7:0] === e.w.data[7:0];
      2'd1: ok = g === e.w;
      2'd2: ok = g.data === e.w.data;
      default: ok = g.addr === e.w.addr && g.data[7:0] === e.w.data[7:0];
    endcase
    // data driven and word addressing during every write
    ok = ok && fl_dq_oe === 1'b1 && fl_addr_m1 === 1'b0;
    if (!ok) begin
      fails++;
      $display("BAD %0t write %h expected %h", $time, g, e.w);
    end
  endtask
  task automatic cmp_rd(input logic [15:0] g);
    logic [15:0] e;
    logic        ok;
    ok = rq.size() != 0;
    e  = ok ? rq.pop_front() : 16'h0000;
    n_compared++;
    if (!ok || g !== e) begin
      fails++;
      $display("BAD %0t read %h expected %h", $time, g, e);
    end
  endtask
  // monitors retire the oldest note per observed result
  always @(posedge fl_we_n) if (rst_n && fl_ce_n === 1'b0) cmp_wr({fl_addr, fl_dq_o});
  always @(posedge clk_sys) if (rsp_valid === 1'b1) cmp_rd(rsp_data);
  task automatic pw(input logic [19:0] wa, input logic [15:0] wd, input logic [1:0] k);
    wq.push_back('{w: '{addr: wa, data: wd}, k: k});
  endtask
  task automatic pfx(input logic [7:0] d3);
    pw({9'h0, A_555}, {8'h00, D_AA}, 2'd0);
    pw({9'h0, A_2AA}, {8'h00, D_55}, 2'd0);
    if (d3 != 8'h00) pw({9'h0, A_555}, {8'h00, d3}, 2'd0);
  endtask
  // note the expected pins, hand over one request, wait for completion
  task automatic op(input fcd_op_t o, input logic [19:0] ra, input logic [15:0] rdat, input logic bm);
    int n;
    case (o)
      FCD_OP_PROG, FCD_OP_SECID_PROG: begin
        pfx((o == FCD_OP_PROG) ? D_PROG : D_SPRG);
        pw(ra, rdat, 2'd1);
      end
      FCD_OP_SECT_ERASE, FCD_OP_BLK_ERASE, FCD_OP_CHIP_ERASE: begin
        pfx(D_ERS);
        pfx(8'h00);
        if (o == FCD_OP_CHIP_ERASE) pw({9'h0, A_555}, {8'h00, D_CHIP}, 2'd0);
        else pw(ra, {8'h00, (o == FCD_OP_SECT_ERASE) ? D_SEC : D_BLK}, 2'd3);
      end
      FCD_OP_SUSPEND, FCD_OP_RESUME, FCD_OP_EXIT_SHORT:
        pw(20'h0, {8'h00, (o == FCD_OP_SUSPEND) ? D_SUSP : (o == FCD_OP_RESUME) ? D_RES : D_EXIT}, 2'd0);
      FCD_OP_SECID_QUERY, FCD_OP_EXIT_LONG: pfx((o == FCD_OP_SECID_QUERY) ? D_SQRY : D_EXIT);
      FCD_OP_SECID_LOCK: begin
        pfx(D_SLCK);
        pw(20'h0, D_LOCK_WORD, 2'd2);
      end
      FCD_OP_ID_ENTRY, FCD_OP_QRY_ENTRY: begin
        pfx(8'h00);
        pw({ra[19:11], A_555}, {8'h00, (o == FCD_OP_ID_ENTRY) ? D_ID : D_QRY}, 2'd3);
      end
      FCD_OP_QRY_SHORT: pw({ra[19:11], A_55}, {8'h00, D_QRY}, 2'd3);
      FCD_OP_READ: rq.push_back(bm ? {8'h00, rdat[7:0]} : rdat);
      default: ;
    endcase
    @(posedge clk_sys);
    #1;
    req       = '{op: o, addr: ra, data: rdat};
    byte_mode = bm;
    req_valid = 1'b1;
    for (n = 0; req_ready !== 1'b1 && n < 100; n++) @(posedge clk_sys) #1;
    if (n >= 100) begin
      fails++;
      $display("BAD %0t request not taken", $time);
    end
    @(posedge clk_sys);
    #1;
    req_valid = 1'b0;
    for (n = 0; (busy !== 1'b0 || dev_ready !== 1'b1) && n < 3000; n++) @(posedge clk_sys) #1;
    if (n >= 3000) begin
      fails++;
      $display("BAD %0t request did not complete", $time);
    end
  endtask
  // main sequence
  initial begin
    repeat (6) @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
    for (int i = 0; i < 3; i++) begin
      d1 = rnd();
      a  = {d1[3:0], rnd()};
      op(FCD_OP_PROG, a, d1, 1'b0);
      op(FCD_OP_SECT_ERASE, a, 16'h0, 1'b0);
      op(FCD_OP_BLK_ERASE, ~a, 16'h0, 1'b0);
      op(FCD_OP_READ, a, ~a[15:0], 1'b0);
    end
    op(FCD_OP_CHIP_ERASE, a, 16'h0, 1'b0);
    op(FCD_OP_SUSPEND, a, 16'h0, 1'b0);
    op(FCD_OP_RESUME, a, 16'h0, 1'b0);
    op(FCD_OP_ID_ENTRY, 20'hC0000, 16'h0, 1'b0);
    op(FCD_OP_READ, 20'hC0000, MAKER, 1'b0);
    op(FCD_OP_READ, 20'hC0001, PART, 1'b0);
    op(FCD_OP_READ, 20'h40001, 16'hFFFE, 1'b0);
    op(FCD_OP_EXIT_SHORT, 20'h0, 16'h0, 1'b0);
    op(FCD_OP_READ, 20'hC0001, 16'hFFFE, 1'b0);
    for (int m = 0; m < 2; m++) begin
      op(m ? FCD_OP_QRY_SHORT : FCD_OP_QRY_ENTRY, 20'h40000, 16'h0, 1'b0);
      for (int o = 16; o <= 52; o++) op(FCD_OP_READ, {12'h400, 8'(o)}, {8'h00, QX[o - 16]}, m[0]);
      op(m ? FCD_OP_EXIT_LONG : FCD_OP_EXIT_SHORT, 20'h0, 16'h0, 1'b0);
      op(FCD_OP_READ, 20'h40010, 16'hFFEF, 1'b0);
    end
    d1 = rnd();
    d2 = rnd();
    op(FCD_OP_SECID_QUERY, 20'h0, 16'h0, 1'b0);
    op(FCD_OP_READ, 20'h00003, FACT, 1'b0);
    op(FCD_OP_READ, SEC_LOCK_ADDR, 16'h0008, 1'b0);
    op(FCD_OP_SECID_PROG, SECID_HI, d1, 1'b0);
    op(FCD_OP_SECID_PROG, SECID_HI, d2, 1'b0);
    op(FCD_OP_READ, SECID_HI, d1 & d2, 1'b0);
    op(FCD_OP_SECID_LOCK, 20'h0, 16'h0, 1'b1);
    op(FCD_OP_READ, SEC_LOCK_ADDR, 16'h0000, 1'b0);
    op(FCD_OP_SECID_PROG, SECID_HI, 16'h0000, 1'b0);
    op(FCD_OP_READ, SECID_HI, d1 & d2, 1'b0);
    op(FCD_OP_QRY_SHORT, 20'h0, 16'h0, 1'b0);
    op(FCD_OP_HW_RESET, 20'h0, 16'h0, 1'b0);
    op(FCD_OP_READ, 20'h00010, 16'hFFEF, 1'b0);
    // let the last read pulse reach the monitor
    repeat (2) @(posedge clk_sys);
    end_sim();
  end
  // watchdog
  initial begin
    #400000;
    fails++;
    $display("BAD %0t watchdog expired", $time);
    end_sim();
  end
endmodule
